// [design/context_descriptor_walk_check.sv]
// Two-level context-entry walk, region-size check, abort and event reporting
`timescale 1ns/1ps

module context_descriptor_walk_check #(
   parameter int unsigned SSID_W = 20
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic req_valid_i,
   input wire cd_walk_pkg::walk_req_t req_i,
   output logic req_ready_o,
   output logic mem_req_o,
   output logic [cd_walk_pkg::PA_W-1:0] mem_addr_o,
   input wire logic mem_rsp_valid_i,
   input wire logic [63:0] mem_rsp_data_i,
   output logic rsp_valid_o,
   output cd_walk_pkg::walk_rsp_t rsp_o,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic irq_o
);
   import cd_walk_pkg::*;

   // ---------------------------------------------------------------
   // Parameter guard
   // ---------------------------------------------------------------
   // Index split needs more identifier bits than the widest level-2 table
   if (SSID_W < SPLIT_64K + 1 || SSID_W > SSID_MAX_W) begin : g_bad_ssid_w
      $error("SSID_W out of supported range");
   end

   // Base plus scaled index; used for every table lookup
   function automatic logic [PA_W-1:0] addr_at(input logic [PA_W-1:0] base,
                                               input logic [SSID_MAX_W-1:0] index,
                                               input int unsigned shift);
      logic [PA_W-1:0] offs;
      offs = PA_W'(index) << shift;
      return base + offs;
   endfunction : addr_at

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   walk_state_t state_ff, nxt_state;
   walk_req_t req_ff;
   logic req_ready_ff;
   logic mem_req_ff;
   logic [PA_W-1:0] mem_addr_ff;
   logic rsp_valid_ff;
   walk_rsp_t rsp_ff;
   logic [CTRL_W-1:0] ctrl_ff;
   logic [EV_W-1:0] status_ff;
   logic [EV_W-1:0] mask_ff;
   logic irq_ff;
   logic [31:0] rdata_ff;

   // ---------------------------------------------------------------
   // Walk address decode
   // ---------------------------------------------------------------
   wire logic accept;
   wire walk_req_t cur_req;
   wire logic two_level;
   wire logic [SSID_MAX_W-1:0] ssid_mask;
   wire logic [SSID_MAX_W-1:0] ssid_eff;
   wire logic [31:0] split;
   wire logic [SSID_MAX_W-1:0] l1_index;
   wire logic [SSID_MAX_W-1:0] l2_index;
   wire logic [PA_W-1:0] l2_base;
   wire logic [PA_W-1:0] l1_addr;
   wire logic [PA_W-1:0] cd2_addr;
   wire logic [PA_W-1:0] cd_lin_addr;

   // While idle the incoming request steers decode, later the held copy
   assign accept = req_valid_i & req_ready_ff & (state_ff == S_IDLE);
   assign cur_req = (state_ff == S_IDLE) ? req_i : req_ff;
   assign two_level = cur_req.stage1_en & cur_req.substream_en & (cur_req.fmt != FMT_LINEAR);
   assign ssid_mask = SSID_MAX_W'((64'h1 << SSID_W) - 64'h1);
   // A transaction without an identifier walks as identifier zero
   assign ssid_eff = cur_req.has_ssid ? (cur_req.ssid & ssid_mask) : '0;
   assign split = (cur_req.fmt == FMT_2L_64K) ? SPLIT_64K : SPLIT_4K;
   assign l1_index = ssid_eff >> split;
   assign l2_index = ssid_eff & SSID_MAX_W'((32'h1 << split) - 32'h1);
   // Level-2 base keeps only bits 51:12 of the level-1 entry
   assign l2_base = PA_W'(mem_rsp_data_i[PA_W-1:L2_LSB]) << L2_LSB;
   assign l1_addr = addr_at(cur_req.ctx_ptr, l1_index, L1_ENTRY_SHIFT);
   assign cd2_addr = addr_at(l2_base, l2_index, CD_SHIFT);
   assign cd_lin_addr = addr_at(cur_req.ctx_ptr, ssid_eff, CD_SHIFT);

   // ---------------------------------------------------------------
   // Fetched entry decode
   // ---------------------------------------------------------------
   wire logic l1_rsp;
   wire logic cd_rsp;
   wire logic l1_valid;
   wire logic bad_ssid;
   wire logic bad_cd;
   wire logic cd_fmt64;
   wire logic cd_illegal;
   wire logic [5:0] cd_eff_size;

   // Responses outside a wait state are stray and ignored
   assign l1_rsp = (state_ff == S_L1_WAIT) & mem_rsp_valid_i;
   assign cd_rsp = (state_ff == S_CD_WAIT) & mem_rsp_valid_i;
   assign l1_valid = mem_rsp_data_i[L1_VALID_BIT];
   assign bad_ssid = l1_rsp & ~l1_valid;
   assign cd_fmt64 = mem_rsp_data_i[FMT64_BIT];
   assign bad_cd = cd_rsp & cd_illegal;

   region_size_check u_size (
      .fmt64_i(cd_fmt64),
      .size_i(mem_rsp_data_i[TSZ_LSB +: TSZ_W]),
      .granule_i(mem_rsp_data_i[GRAN_LSB +: 2]),
      .walk_disable_i(mem_rsp_data_i[WALKDIS_BIT]),
      .newer_rev_i(ctrl_ff[CTRL_NEWER]),
      .va52_i(ctrl_ff[CTRL_VA52]),
      .oor_illegal_i(ctrl_ff[CTRL_OOR_ILL]),
      .illegal_o(cd_illegal),
      .eff_size_o(cd_eff_size)
   );

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   wire logic nxt_mem_req;
   wire logic [PA_W-1:0] nxt_mem_addr;
   wire logic finished;
   wire walk_rsp_t nxt_rsp;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         S_IDLE: begin
            if (accept) begin
               nxt_state = two_level ? S_L1_WAIT : S_CD_WAIT;
            end
         end
         S_L1_WAIT: begin
            if (l1_rsp) begin
               nxt_state = l1_valid ? S_CD_WAIT : S_IDLE;
            end
         end
         S_CD_WAIT: begin
            if (cd_rsp) begin
               nxt_state = S_IDLE;
            end
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   // One read per fetch; pointer of an invalid entry is never used
   assign nxt_mem_req = accept | (l1_rsp & l1_valid);
   assign nxt_mem_addr = (state_ff == S_IDLE) ? (two_level ? l1_addr : cd_lin_addr) : cd2_addr;
   assign finished = bad_ssid | cd_rsp;
   assign nxt_rsp = '{abort: bad_ssid | bad_cd,
                      bad_substream: bad_ssid,
                      bad_context: bad_cd,
                      secure: req_ff.secure,
                      fmt64: cd_rsp & cd_fmt64,
                      region_size: cd_rsp ? cd_eff_size : 6'h00};

   // Walk registers
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state_ff <= S_IDLE;
         req_ready_ff <= 1'b0;
         mem_req_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         req_ready_ff <= (nxt_state == S_IDLE);
         mem_req_ff <= nxt_mem_req;
         rsp_valid_ff <= finished;
      end
   end

   // Data path holds need no reset; qualified by the valid strobes
   always_ff @(posedge core_clk_i) begin
      if (accept) begin
         req_ff <= req_i;
      end
      if (nxt_mem_req) begin
         mem_addr_ff <= nxt_mem_addr;
      end
      if (finished) begin
         rsp_ff <= nxt_rsp;
      end
   end

   // ---------------------------------------------------------------
   // Register port and interrupt
   // ---------------------------------------------------------------
   wire logic wr_ctrl;
   wire logic wr_status;
   wire logic wr_mask;
   wire logic [EV_W-1:0] events;
   wire logic [EV_W-1:0] nxt_status;
   wire logic [31:0] rd_value;

   assign wr_ctrl = reg_wr_i & (reg_addr_i == REG_CTRL);
   assign wr_status = reg_wr_i & (reg_addr_i == REG_STATUS);
   assign wr_mask = reg_wr_i & (reg_addr_i == REG_MASK);
   assign events = {finished, bad_cd, bad_ssid};
   // Write-one-to-clear; a new event in the same cycle survives
   assign nxt_status = (status_ff & ~(wr_status ? reg_wdata_i[EV_W-1:0] : 3'h0)) | events;
   assign rd_value = (reg_addr_i == REG_CTRL) ? {29'h0, ctrl_ff} :
                     (reg_addr_i == REG_STATUS) ? {29'h0, status_ff} :
                     (reg_addr_i == REG_MASK) ? {29'h0, mask_ff} :
                     (reg_addr_i == REG_RESULT) ? {21'h0, state_ff, rsp_ff.abort, rsp_ff.fmt64,
                                                   rsp_ff.region_size} : 32'h0000_0000;

   // Read data lives only in the cycle after the strobe
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         ctrl_ff <= CTRL_RST;
         status_ff <= EV_RST;
         mask_ff <= EV_RST;
         irq_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         ctrl_ff <= wr_ctrl ? reg_wdata_i[CTRL_W-1:0] : ctrl_ff;
         status_ff <= nxt_status;
         mask_ff <= wr_mask ? reg_wdata_i[EV_W-1:0] : mask_ff;
         irq_ff <= |(nxt_status & (wr_mask ? reg_wdata_i[EV_W-1:0] : mask_ff));
         rdata_ff <= reg_rd_i ? rd_value : 32'h0000_0000;
      end
   end

   assign req_ready_o = req_ready_ff;
   assign mem_req_o = mem_req_ff;
   assign mem_addr_o = mem_addr_ff;
   assign rsp_valid_o = rsp_valid_ff;
   assign rsp_o = rsp_ff;
   assign reg_rdata_o = rdata_ff;
   assign irq_o = irq_ff;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   a_two_level_start: assert property (accept && two_level |=> mem_req_o && state_ff == S_L1_WAIT)
      else $error("two-level walk did not fetch level-1 entry");
   a_valid_walks_on: assert property (l1_rsp && l1_valid |=> mem_req_o && state_ff == S_CD_WAIT)
      else $error("valid level-1 entry did not fetch level 2");
   a_l2_base_bits: assert property (l1_rsp && l1_valid |=> mem_addr_o[PA_W-1:L2_LSB]
      >= $past(mem_rsp_data_i[PA_W-1:L2_LSB]))
      else $error("level-2 address not built from entry bits");
   a_bad_ssid_abort: assert property (bad_ssid |=> rsp_valid_o && rsp_o.abort
      && rsp_o.bad_substream && !mem_req_o && status_ff[EV_BAD_SSID])
      else $error("invalid level-1 entry not aborted");
   a_bad_cd_event: assert property (bad_cd |=> rsp_valid_o && rsp_o.abort && rsp_o.bad_context
      && rsp_o.secure == $past(req_ff.secure))
      else $error("illegal context entry not reported");
   a_format_follows: assert property (cd_rsp |=> rsp_o.fmt64 == $past(cd_fmt64))
      else $error("table format flag not carried");
   a_fmt32_legal: assert property (cd_rsp && !cd_fmt64 |-> !cd_illegal && cd_eff_size[5:3] == 3'h0)
      else $error("32-bit region size mishandled");
   a_fmt64_max: assert property (cd_rsp && cd_fmt64 && !mem_rsp_data_i[WALKDIS_BIT]
      && mem_rsp_data_i[5:0] > 6'h27 |-> cd_illegal || cd_eff_size == 6'h27)
      else $error("oversize region accepted");
   a_fmt64_min: assert property (cd_rsp && cd_fmt64 && !mem_rsp_data_i[WALKDIS_BIT]
      && !ctrl_ff[CTRL_NEWER] && mem_rsp_data_i[5:0] < 6'h10 |-> cd_illegal || cd_eff_size == 6'h10)
      else $error("undersize region accepted");
   a_newer_strict: assert property (cd_rsp && ctrl_ff[CTRL_NEWER] && cd_fmt64
      && !mem_rsp_data_i[WALKDIS_BIT] && (mem_rsp_data_i[5:0] > 6'h27 || mem_rsp_data_i[5:0] < 6'h0c)
      |-> cd_illegal)
      else $error("newer revision did not refuse range");
   a_base_clamp: assert property (cd_rsp && !ctrl_ff[CTRL_NEWER] && !ctrl_ff[CTRL_OOR_ILL]
      |=> !rsp_o.bad_context)
      else $error("base revision clamp mode refused entry");
   a_walkdis_ignore: assert property (cd_rsp && mem_rsp_data_i[WALKDIS_BIT] |-> !cd_illegal)
      else $error("size checked while walk disabled");

   c_two_level_ok: cover property (l1_rsp && l1_valid ##[1:50] cd_rsp && !cd_illegal);
   c_bad_ssid: cover property (bad_ssid);
   bad_context_event: cover property (bad_cd);
   c_irq: cover property (irq_o);

endmodule : context_descriptor_walk_check

// [design/region_size_check.sv]
// Region-size legality and effective value for a fetched context entry
`timescale 1ns/1ps

module region_size_check (
   input wire logic fmt64_i,
   input wire logic [5:0] size_i,
   input wire logic [1:0] granule_i,
   input wire logic walk_disable_i,
   input wire logic newer_rev_i,
   input wire logic va52_i,
   input wire logic oor_illegal_i,
   output logic illegal_o,
   output logic [5:0] eff_size_o
);
   import cd_walk_pkg::*;

   // ---------------------------------------------------------------
   // Range limits
   // ---------------------------------------------------------------
   wire logic small_ok;
   wire logic [5:0] min_size;
   wire logic too_big;
   wire logic too_small;
   wire logic out_of_range;

   // Lower floor only with the newer revision, 52-bit VAs and 64KB granule
   assign small_ok = newer_rev_i & va52_i & (granule_i == GRAN_64K);
   assign min_size = small_ok ? TSZ_MIN_52 : TSZ_MIN;
   assign too_big = size_i > TSZ_MAX;
   assign too_small = size_i < min_size;
   // 32-bit format has no illegal values; walk-disabled field is ignored
   assign out_of_range = fmt64_i & ~walk_disable_i & (too_big | too_small);

   // ---------------------------------------------------------------
   // Verdict and clamped value
   // ---------------------------------------------------------------
   // Base revision may clamp instead of refusing, chosen by software
   assign illegal_o = out_of_range & (newer_rev_i | oor_illegal_i);
   assign eff_size_o = walk_disable_i ? size_i :
                       !fmt64_i ? {3'h0, size_i[2:0]} :
                       too_big ? TSZ_MAX :
                       too_small ? TSZ_MIN : size_i;

endmodule : region_size_check

// [pkg/cd_walk_pkg.sv]
// Shared constants, field layouts and types for the context-entry walk checker
package cd_walk_pkg;

   // ---------------------------------------------------------------
   // Addresses and table geometry
   // ---------------------------------------------------------------
   localparam int unsigned PA_W = 52;
   localparam int unsigned SSID_MAX_W = 20;
   localparam int unsigned L2_LSB = 12;
   localparam int unsigned L1_VALID_BIT = 0;
   localparam int unsigned L1_ENTRY_SHIFT = 3;
   localparam int unsigned CD_SHIFT = 6;
   localparam int unsigned SPLIT_4K = 6;
   localparam int unsigned SPLIT_64K = 10;
   localparam logic [1:0] FMT_LINEAR = 2'h0;
   localparam logic [1:0] FMT_2L_64K = 2'h2;

   // ---------------------------------------------------------------
   // Context entry word 0 fields
   // ---------------------------------------------------------------
   localparam int unsigned TSZ_LSB = 0;
   localparam int unsigned TSZ_W = 6;
   localparam int unsigned GRAN_LSB = 6;
   localparam int unsigned WALKDIS_BIT = 14;
   localparam int unsigned FMT64_BIT = 41;
   localparam logic [1:0] GRAN_64K = 2'h1;
   localparam logic [5:0] TSZ_MAX = 6'h27;
   localparam logic [5:0] TSZ_MIN = 6'h10;
   localparam logic [5:0] TSZ_MIN_52 = 6'h0c;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_MASK = 4'h8;
   localparam logic [3:0] REG_RESULT = 4'hc;
   localparam int unsigned CTRL_W = 3;
   localparam int unsigned CTRL_NEWER = 0;
   localparam int unsigned CTRL_VA52 = 1;
   localparam int unsigned CTRL_OOR_ILL = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam int unsigned EV_W = 3;
   localparam int unsigned EV_BAD_SSID = 0;
   localparam int unsigned EV_BAD_CD = 1;
   localparam int unsigned EV_DONE = 2;
   localparam logic [2:0] EV_RST = 3'h0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic stage1_en;
      logic substream_en;
      logic [1:0] fmt;
      logic secure;
      logic has_ssid;
      logic [SSID_MAX_W-1:0] ssid;
      logic [PA_W-1:0] ctx_ptr;
   } walk_req_t;

   typedef struct packed {
      logic abort;
      logic bad_substream;
      logic bad_context;
      logic secure;
      logic fmt64;
      logic [5:0] region_size;
   } walk_rsp_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'h1,
      S_L1_WAIT = 3'h2,
      S_CD_WAIT = 3'h4
   } walk_state_t;

endpackage : cd_walk_pkg

// [tb/context_descriptor_walk_check_tb_top.sv]
// Self-checking bench: random walks against a behavioural expectation, registers and interrupt
`timescale 1ns/1ps

module context_descriptor_walk_check_tb_top;
   import cd_walk_pkg::*;

   // ------------------------------------------------------------
   // Signals, bench state and instances
   // ------------------------------------------------------------
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic req_valid_i = 1'b0;
   walk_req_t req_i = '0;
   logic req_ready_o, mem_req_o, mem_rsp_valid_i, rsp_valid_o, irq_o;
   logic [PA_W-1:0] mem_addr_o;
   logic [63:0] mem_rsp_data_i;
   walk_rsp_t rsp_o;
   logic [3:0] reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0000_0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic [3:0] lat = 4'h1;
   logic [2:0] ctrl_m = 3'h0;
   logic [2:0] mask_m = 3'h0;
   logic [2:0] status_m = 3'h0;
   logic [63:0] exp_addr [$];
   logic [5:0] bnd [8] = '{6'h0b, 6'h0c, 6'h0f, 6'h10, 6'h27, 6'h28, 6'h00, 6'h3f};
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;

   context_descriptor_walk_check #(.SSID_W(SSID_MAX_W)) dut_u (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i), .req_i(req_i),
      .req_ready_o(req_ready_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
      .mem_rsp_valid_i(mem_rsp_valid_i), .mem_rsp_data_i(mem_rsp_data_i), .rsp_valid_o(rsp_valid_o),
      .rsp_o(rsp_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o)
   );

   desc_mem_model mem_u (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
      .delay_i(lat), .mem_rsp_valid_o(mem_rsp_valid_i), .mem_rsp_data_o(mem_rsp_data_i)
   );

   // Clock of 8 ns period
   always #4 core_clk_i = ~core_clk_i;

   // ------------------------------------------------------------
   // Comparison, bus and walk tasks
   // ------------------------------------------------------------
   task summarize;
      if (miscompares == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic check_val(input string name, input logic [63:0] e, input logic [63:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask : check_val

   // Aborted walks leave size and format open, so only the flags are compared then
   task automatic check_rsp(input walk_rsp_t e, input walk_rsp_t g);
      walk_rsp_t m;
      m = e.abort ? 11'h780 : 11'h7ff;
      comparisons++;
      if ((g & m) !== (e & m)) begin
         miscompares++;
         $display("wrong value rsp_o expected %h seen %h", e, g);
      end
   endtask : check_rsp

   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : reg_wr

   // Read data stands only in the cycle after the strobe; irq is checked alongside
   task automatic reg_chk(input string name, input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge core_clk_i);
      check_val(name, 64'(e & m), 64'(reg_rdata_o & m));
      check_val("irq_o", 64'(|(status_m & mask_m)), 64'(irq_o));
      @(posedge core_clk_i);
   endtask : reg_chk

   // Builds random tables, predicts the reads and the answer, then runs one walk
   task automatic rand_walk(output walk_rsp_t e);
      walk_req_t r;
      logic [PA_W-1:0] l2, l1a, ca;
      logic [63:0] l1, cw;
      logic [5:0] sz, lo;
      int unsigned ss, split;
      logic ill;
      int k;
      mem_u.mem.delete();
      r = '0;
      r.stage1_en = ($urandom % 8) != 0;
      r.substream_en = ($urandom % 4) != 0;
      r.fmt = 2'($urandom % 3);
      r.secure = 1'($urandom);
      r.has_ssid = r.substream_en & 1'($urandom);
      r.ssid = 20'($urandom);
      r.ctx_ptr = {5'h00, 35'({$urandom, $urandom}), 12'h000};
      l2 = {5'h01, 35'({$urandom, $urandom}), 12'h000};
      ss = r.has_ssid ? r.ssid : 0;
      split = (r.fmt == FMT_2L_64K) ? SPLIT_64K : SPLIT_4K;
      sz = ($urandom % 2) ? bnd[$urandom % 8] : 6'($urandom);
      cw = {$urandom, $urandom};
      cw[5:0] = sz;
      cw[41] = ($urandom % 4) != 0;
      cw[14] = cw[41] & (($urandom % 4) == 0);
      e = '0;
      e.secure = r.secure;
      e.fmt64 = cw[41];
      ca = r.ctx_ptr + (ss << CD_SHIFT);
      if (r.stage1_en && r.substream_en && r.fmt != FMT_LINEAR) begin
         // Junk in the low bits must not leak into the level-2 base
         l1a = r.ctx_ptr + ((ss >> split) << L1_ENTRY_SHIFT);
         l1 = {12'h000, l2[51:12], 11'($urandom), 1'(($urandom % 5) != 0)};
         mem_u.mem[l1a] = l1;
         exp_addr.push_back(64'(l1a));
         ca = {l1[51:12], 12'h000} + ((ss & ((1 << split) - 1)) << CD_SHIFT);
         e.abort = !l1[0];
         e.bad_substream = !l1[0];
      end
      if (!e.abort) begin
         mem_u.mem[ca] = cw;
         exp_addr.push_back(64'(ca));
         lo = (ctrl_m[CTRL_NEWER] && ctrl_m[CTRL_VA52] && cw[7:6] == GRAN_64K) ? TSZ_MIN_52 : TSZ_MIN;
         ill = cw[41] && !cw[14] && (sz > TSZ_MAX || sz < lo) && (ctrl_m[CTRL_NEWER] || ctrl_m[CTRL_OOR_ILL]);
         e.abort = ill;
         e.bad_context = ill;
         e.region_size = !cw[41] ? {3'h0, sz[2:0]} : cw[14] ? sz : (sz > TSZ_MAX) ? TSZ_MAX : (sz < lo) ? lo : sz;
      end
      req_i <= r;
      req_valid_i <= 1'b1;
      @(negedge core_clk_i);
      while (req_ready_o !== 1'b1) @(negedge core_clk_i);
      @(posedge core_clk_i);
      req_valid_i <= 1'b0;
      @(negedge core_clk_i);
      check_val("req_ready_o", 64'h0000_0000_0000_0000, 64'(req_ready_o));
      k = 0;
      do begin
         @(negedge core_clk_i);
         k++;
      end while (rsp_valid_o !== 1'b1 && k < 100);
      check_val("rsp_valid_o", 64'h0000_0000_0000_0001, 64'(rsp_valid_o));
      check_val("req_ready_o", 64'h0000_0000_0000_0001, 64'(req_ready_o));
      check_rsp(e, rsp_o);
      check_val("reads left", 64'h0000_0000_0000_0000, 64'(exp_addr.size()));
      @(posedge core_clk_i);
   endtask : rand_walk

   // ------------------------------------------------------------
   // Monitors and main sequence
   // ------------------------------------------------------------
   // Every read address must be the next one predicted; an extra read finds the queue empty
   always @(negedge core_clk_i) begin
      if (!reset_i && mem_req_o === 1'b1) begin
         check_val("mem_addr_o", (exp_addr.size() > 0) ? exp_addr.pop_front() : '1, 64'(mem_addr_o));
      end
   end

   // Watchdog: about 1500 cycles are expected, so a hang ends the run at 20000, far above that
   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         summarize();
      end
   end

   initial begin
      walk_rsp_t e;
      logic [2:0] clr;
      void'($urandom(63415));
      repeat (6) @(posedge core_clk_i);
      reset_i <= 1'b0;
      @(posedge core_clk_i);
      reg_chk("ctrl", REG_CTRL, 32'h0000_0000, 32'hffff_ffff);
      reg_chk("status", REG_STATUS, 32'h0000_0000, 32'hffff_ffff);
      reg_chk("mask", REG_MASK, 32'h0000_0000, 32'hffff_ffff);
      reg_wr(4'h6, 32'hffff_ffff);
      reg_chk("unmapped", 4'h6, 32'h0000_0000, 32'hffff_ffff);
      reg_wr(REG_CTRL, 32'hffff_ffff);
      reg_chk("ctrl", REG_CTRL, 32'h0000_0007, 32'hffff_ffff);
      for (int n = 0; n < 80; n++) begin
         ctrl_m = 3'($urandom);
         mask_m = 3'($urandom);
         lat <= 4'(1 + $urandom % 4);
         reg_wr(REG_CTRL, 32'(ctrl_m));
         reg_wr(REG_MASK, 32'(mask_m));
         rand_walk(e);
         status_m = status_m | {1'b1, e.bad_context, e.bad_substream};
         reg_chk("status", REG_STATUS, 32'(status_m), 32'hffff_ffff);
         clr = 3'($urandom);
         reg_wr(REG_STATUS, 32'(clr));
         status_m = status_m & ~clr;
         reg_chk("result", REG_RESULT, {21'h00_0000, 3'h1, e.abort, e.fmt64, e.region_size},
                 e.abort ? 32'h0000_0780 : 32'h0000_07ff);
      end
      summarize();
   end
endmodule : context_descriptor_walk_check_tb_top

// [tb/desc_mem_model.sv]
// Behavioural system memory that holds the descriptor tables and answers the walker's reads
`timescale 1ns/1ps

module desc_mem_model (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic mem_req_i,
   input wire logic [51:0] mem_addr_i,
   input wire logic [3:0] delay_i,
   output logic mem_rsp_valid_o = 1'b0,
   output logic [63:0] mem_rsp_data_o = 64'h0000_0000_0000_0000
);
   // Table words; the bench rewrites them only between walks and the walker keeps
   // no copies across walks, so no invalidation step is owed
   logic [63:0] mem [logic [51:0]];
   logic [63:0] word_ff;
   int wait_ff;

   // One read at a time, answered after delay_i cycles; the data line flips while idle
   // so that a stale word can never pass for a fresh answer
   always @(posedge core_clk_i) begin
      if (reset_i) begin
         wait_ff <= 0;
         mem_rsp_valid_o <= 1'b0;
      end else if (mem_req_i) begin
         word_ff <= mem.exists(mem_addr_i) ? mem[mem_addr_i] : 64'h0000_0000_0000_0000;
         wait_ff <= int'(delay_i);
         mem_rsp_valid_o <= 1'b0;
         mem_rsp_data_o <= ~mem_rsp_data_o;
      end else if (wait_ff == 1) begin
         wait_ff <= 0;
         mem_rsp_valid_o <= 1'b1;
         mem_rsp_data_o <= word_ff;
      end else begin
         wait_ff <= (wait_ff > 1) ? wait_ff - 1 : 0;
         mem_rsp_valid_o <= 1'b0;
         mem_rsp_data_o <= ~mem_rsp_data_o;
      end
   end
endmodule : desc_mem_model
